// ==== rtl/cpw_pkg.sv ====
// Constants, field layouts and helpers shared by the PWM output block
package cpw_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // Unit control register
  localparam logic [7:0] ADDR_DUTY_HI = 8'h04; // Duty high byte
  localparam logic [7:0] ADDR_PERIOD  = 8'h08; // Period limit
  localparam logic [7:0] ADDR_TCTRL   = 8'h0C; // Period timer control
  localparam logic [7:0] ADDR_TIMER   = 8'h10; // Period timer, read only
  localparam logic [7:0] ADDR_STATUS  = 8'h14; // Sticky events, write 1 clear
  localparam logic [7:0] ADDR_MASK    = 8'h18; // Interrupt mask
  localparam logic [7:0] ADDR_DIR     = 8'h1C; // Pin direction bit
  localparam logic [7:0] ADDR_INFO    = 8'h20; // Resolution and live state

  // Values after reset
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_DUTY   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [2:0] RST_TCTRL  = 3'h0;
  localparam logic       RST_DIR    = 1'b1;  // Pin starts as input

  // Mode field: upper two bits both set selects PWM
  localparam logic [1:0] MODE_PWM = 2'h3;

  // Prescale select codes and the prescaler masks they give
  localparam logic [1:0] PSC_DIV1  = 2'h0;
  localparam logic [1:0] PSC_DIV4  = 2'h1;
  localparam logic [3:0] MSK_DIV1  = 4'h0;
  localparam logic [3:0] MSK_DIV4  = 4'h3;
  localparam logic [3:0] MSK_DIV16 = 4'hF;

  // Quarter-count phase that ends one timer input clock
  localparam logic [1:0] QPH_LAST = 2'h3;

  // Unit control register layout
  typedef struct packed {
    logic [1:0] spare;    // Reads as zero
    logic [1:0] duty_lo;  // Duty low bits
    logic [3:0] mode;     // Mode field
  } cpw_ctrl_s;

  // Period timer control layout
  typedef struct packed {
    logic       on;       // Period timer on
    logic [1:0] psc;      // Period prescale select
  } cpw_tctrl_s;

  // Resolution in bits: log2 of four times (limit plus one), floored
  function automatic logic [3:0] res_bits(input logic [7:0] lim);
    logic [8:0] n;
    logic [3:0] r;
    n = {1'b0, lim} + 9'h001;
    r = 4'h2;
    for (int i = 1; i < 9; i++) begin
      if (n[i]) r = 4'(i + 2);
    end
    return r;
  endfunction
endpackage

// ==== rtl/cpw_pwm_top.sv ====
// APB-mapped capture/compare unit in PWM mode with period timer
//
// What this block and its software do
// RQ1 - Duty settings count is two to resolution
// RQ2 - Resolution is log2 of 4*(limit+1)
// RQ3 - Width above period leaves pin unchanged
// RQ4 - Sleep freezes timer, state and pin
// RQ5 - After wake timer continues from held value
// RQ6 - PWM rate follows the system clock
// RQ7 - Reset makes pin input, registers default
// RQ8 - Software: disable pin, set limit, mode
// RQ9 - Software loads duty high byte, low bits
// RQ10 - Software clears flag, sets prescale, starts
// RQ11 - Software waits flag before enabling pin
// RQ12 - Prescaler divides by 1, 4 or 16
// RQ13 - Match clears timer, flags, drives high
// RQ14 - Output falls at duty quarter-count match
`timescale 1ns/1ns
module cpw_pwm_top #(
  parameter int AW = 8                 // APB address width
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          sleep,
  output logic               pwm_output_pin,
  output logic               pwm_output_pin_oe_n,
  output logic               irq
);

  // Software-visible state
  cpw_pkg::cpw_ctrl_s  ctrl_q;          // Unit control register
  cpw_pkg::cpw_tctrl_s tctrl_q;         // Period timer control
  logic [7:0]          duty_hi_q;       // Duty high byte
  logic [7:0]          period_q;        // Period limit
  logic                dir_q;           // Pin direction bit
  logic                sts_q;           // Period timer flag
  logic                mask_q;          // Interrupt enable

  // Counting chain and latched duty
  logic [1:0]          qph_q;           // Quarter-count phase
  logic [3:0]          psc_q;           // Prescaler
  logic [7:0]          timer_q;         // Period timer
  logic [9:0]          duty_lat_q;      // Duty in use this period

  // Bus answer and output flops
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;
  logic                out_q;
  logic                oe_n_q;
  logic                irq_q;

  // Decoded bus and counting events
  logic                acc;             // Access phase, answer pending
  logic                wr;              // Write completes this edge
  logic [AW-1:0]       a;
  logic [3:0]          psc_mask;
  logic                pwm_mode;
  logic                tick;
  logic                period_end;
  logic                fall_hit;
  logic [31:0]         rd_d;
  logic                hit_d;

  assign a        = paddr;
  assign acc      = psel & penable & ~pready_q;
  assign wr       = psel & penable & pready_q & pwrite;
  assign pwm_mode = (ctrl_q.mode[3:2] == cpw_pkg::MODE_PWM);

  // Prescale select to mask; code 2 and 3 both give 16
  always_comb begin
    case (tctrl_q.psc)
      cpw_pkg::PSC_DIV1: psc_mask = cpw_pkg::MSK_DIV1;  // [RQ12]
      cpw_pkg::PSC_DIV4: psc_mask = cpw_pkg::MSK_DIV4;  // [RQ12]
      default:           psc_mask = cpw_pkg::MSK_DIV16; // [RQ12]
    endcase
  end

  // Timer steps once per four clocks times the prescale ratio;
  // every step is a pclk edge, so the rate scales with pclk [RQ6]
  assign tick = tctrl_q.on & ~sleep & (qph_q == cpw_pkg::QPH_LAST)
              & ((psc_q & psc_mask) == psc_mask);              // [RQ4]
  assign period_end = tick & (timer_q == period_q);            // [RQ13]
  // Quarter resolution comes from the phase below the timer [RQ14]
  assign fall_hit   = ~sleep & pwm_mode & tctrl_q.on
                    & ({timer_q, qph_q} == duty_lat_q);

  // Read mux and address decode
  always_comb begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    case (a)
      AW'(cpw_pkg::ADDR_CTRL):    rd_d[7:0] = {2'h0, ctrl_q[5:0]};
      AW'(cpw_pkg::ADDR_DUTY_HI): rd_d[7:0] = duty_hi_q;
      AW'(cpw_pkg::ADDR_PERIOD):  rd_d[7:0] = period_q;
      AW'(cpw_pkg::ADDR_TCTRL):   rd_d[2:0] = tctrl_q;
      AW'(cpw_pkg::ADDR_TIMER):   rd_d[7:0] = timer_q;
      AW'(cpw_pkg::ADDR_STATUS):  rd_d[0]   = sts_q;
      AW'(cpw_pkg::ADDR_MASK):    rd_d[0]   = mask_q;
      AW'(cpw_pkg::ADDR_DIR):     rd_d[0]   = dir_q;
      AW'(cpw_pkg::ADDR_INFO): begin
        rd_d[3:0]   = cpw_pkg::res_bits(period_q);             // [RQ2]
        rd_d[8]     = out_q;
        rd_d[9]     = sleep;
        rd_d[26:16] = {1'b0, period_q, 2'h0} + 11'h004;        // [RQ1]
      end
      default: hit_d = 1'b0;
    endcase
  end

  // One wait state: answer in the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (acc) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~hit_d;
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Register writes; reset restores every default [RQ7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= cpw_pkg::RST_CTRL;
      duty_hi_q <= cpw_pkg::RST_DUTY;
      period_q  <= cpw_pkg::RST_PERIOD;
      tctrl_q   <= cpw_pkg::RST_TCTRL;
      dir_q     <= cpw_pkg::RST_DIR;                           // [RQ7]
      mask_q    <= 1'b0;
    end else if (wr) begin
      case (a)
        AW'(cpw_pkg::ADDR_CTRL):    ctrl_q    <= {2'h0, pwdata[5:0]};
        AW'(cpw_pkg::ADDR_DUTY_HI): duty_hi_q <= pwdata[7:0]; // [RQ9]
        AW'(cpw_pkg::ADDR_PERIOD):  period_q  <= pwdata[7:0];
        AW'(cpw_pkg::ADDR_TCTRL):   tctrl_q   <= pwdata[2:0];
        AW'(cpw_pkg::ADDR_MASK):    mask_q    <= pwdata[0];
        AW'(cpw_pkg::ADDR_DIR):     dir_q     <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Sticky flag: a period end in the clearing cycle still sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= 1'b0;
    end else if (period_end) begin
      sts_q <= 1'b1;                                           // [RQ13]
    end else if (wr && a == AW'(cpw_pkg::ADDR_STATUS) && pwdata[0]) begin
      sts_q <= 1'b0;
    end
  end

  // Counting chain; nothing moves in sleep, so wake resumes in place
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qph_q      <= 2'h0;
      psc_q      <= 4'h0;
      timer_q    <= 8'h00;
      duty_lat_q <= 10'h000;
    end else if (tctrl_q.on && !sleep) begin                   // [RQ4]
      qph_q <= qph_q + 2'h1;                                   // [RQ5]
      if (qph_q == cpw_pkg::QPH_LAST) begin
        psc_q <= tick ? 4'h0 : psc_q + 4'h1;                   // [RQ12]
      end
      if (period_end) begin
        timer_q    <= 8'h00;                                   // [RQ13]
        duty_lat_q <= {duty_hi_q, ctrl_q.duty_lo};             // [RQ13]
      end else if (tick) begin
        timer_q <= timer_q + 8'h01;
      end
    end
  end

  // Output level: rises at period end, falls at duty match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (!pwm_mode) begin
      out_q <= 1'b0;
    end else if (sleep) begin
      out_q <= out_q;                                          // [RQ4]
    end else if (period_end) begin
      // Width past the period would never fall; leave pin alone
      if (duty_hi_q <= period_q) out_q <= 1'b1;                // [RQ3]
    end else if (fall_hit) begin
      out_q <= 1'b0;                                           // [RQ14]
    end
  end

  // Pin enable and interrupt, registered to keep outputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_q <= 1'b1;                                          // [RQ7]
      irq_q  <= 1'b0;
    end else begin
      oe_n_q <= dir_q;                                         // [RQ11]
      irq_q  <= sts_q & mask_q;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign pwm_output_pin      = out_q;
  assign pwm_output_pin_oe_n = oe_n_q;
  assign irq                 = irq_q;

  // Checks on the block's own behaviour
  sequence s_sleep_span;
    sleep ##1 sleep;
  endsequence

  sequence s_quiet8;
    !tick [*8];
  endsequence

  property p_sleep_freeze;
    @(posedge pclk) disable iff (!presetn)
      s_sleep_span |-> $stable(timer_q) && $stable(out_q);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) // [RQ4]
    else $error("state moved during sleep");

  property p_wake_resume;
    @(posedge pclk) disable iff (!presetn)
      sleep ##1 !sleep |-> timer_q == $past(timer_q, 1);
  endproperty
  a_wake_resume: assert property (p_wake_resume) // [RQ5]
    else $error("timer jumped on wake");

  property p_match_clear;
    @(posedge pclk) disable iff (!presetn)
      period_end |=> timer_q == 8'h00 && sts_q;
  endproperty
  a_match_clear: assert property (p_match_clear) // [RQ13]
    else $error("period end did not clear timer or set flag");

  property p_match_high;
    @(posedge pclk) disable iff (!presetn)
      period_end && pwm_mode && duty_hi_q <= period_q |=> out_q;
  endproperty
  a_match_high: assert property (p_match_high) // [RQ13]
    else $error("output not high after period end");

  property p_over_hold;
    @(posedge pclk) disable iff (!presetn)
      period_end && pwm_mode && duty_hi_q > period_q |=> $stable(out_q);
  endproperty
  a_over_hold: assert property (p_over_hold) // [RQ3]
    else $error("pin changed with width above period");

  property p_fall;
    @(posedge pclk) disable iff (!presetn)
      fall_hit && !period_end && out_q |=> !out_q;
  endproperty
  a_fall: assert property (p_fall) // [RQ14]
    else $error("output did not fall at duty match");

  property p_div16;
    @(posedge pclk) disable iff (!presetn)
      tick && tctrl_q.psc[1] && $stable(tctrl_q) |=> s_quiet8;
  endproperty
  a_div16: assert property (p_div16) // [RQ12]
    else $error("timer stepped too soon at divide by 16");

  // A divide-by-four step must be followed by a quiet stretch too
  property p_div4;
    @(posedge pclk) disable iff (!presetn)
      tick && tctrl_q.psc == cpw_pkg::PSC_DIV4 && $stable(tctrl_q)
      |=> s_quiet8;
  endproperty
  a_div4: assert property (p_div4) // [RQ12]
    else $error("timer stepped too soon at divide by 4");

  property p_res_max;
    @(posedge pclk) disable iff (!presetn)
      period_q == 8'hFF |-> cpw_pkg::res_bits(period_q) == 4'hA;
  endproperty
  a_res_max: assert property (p_res_max) // [RQ2]
    else $error("resolution not ten bits at full limit");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      acc |=> pready_q ##1 !pready_q;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("bus answer not one cycle");

  // Interrupt follows the masked flag exactly one clock late
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> irq_q == $past(sts_q & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not follow masked flag");

endmodule // cpw_pwm_top

// ==== tb/cpw_load_model.sv ====
// Load on the PWM pin: measures high time and period in clocks
`timescale 1ns/1ns
module cpw_load_model (
  input  wire logic clk,
  input  wire logic pin,
  input  wire logic oe_n,
  output int        hi_len,
  output int        per_len
);
  int   cnt_q;   // Samples since last rise
  logic last_q;  // Pin level at previous edge

  // Only a driven pin is measured; an input pin floats
  always @(posedge clk) begin
    last_q <= pin;
    cnt_q  <= cnt_q + 1;
    if (!oe_n && pin && !last_q) begin
      per_len <= cnt_q;
      cnt_q   <= 1;
    end
    if (!oe_n && !pin && last_q) hi_len <= cnt_q;
  end
  initial begin
    cnt_q   = 0;
    last_q  = 1'b0;
    hi_len  = 0;
    per_len = 0;
  end
endmodule // cpw_load_model

// ==== tb/cpw_pwm_top_tb.sv ====
// Self-checking bench for the APB PWM output block
`timescale 1ns/1ns
module cpw_pwm_top_tb;
  logic pclk, presetn, psel, penable, pwrite, sleep;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pin, oe_n, irq, er;
  int   hi_len, per_len, n_mismatch, n_checks;

  cpw_pwm_top cpw_pwm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .pwm_output_pin(pin), .pwm_output_pin_oe_n(oe_n), .irq(irq));
  cpw_load_model cpw_load_model_i (.clk(pclk), .pin(pin), .oe_n(oe_n),
    .hi_len(hi_len), .per_len(per_len));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Resolution in whole bits of 4*(limit+1)
  function automatic logic [31:0] f_res(input int lim);
    int r;
    r = 0;
    while ((1 << (r + 1)) <= 4 * (lim + 1)) r++;
    return r;
  endfunction

  // High time in clocks: fall follows the first quarter-count match
  function automatic int f_hi(input int duty, input int dv);
    return 4 * dv * (duty >> 2) + (duty & 3) + 1;
  endfunction

  // Poll the period flag until set; a run-out counts as a mismatch
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(0, cpw_pkg::ADDR_STATUS, 0);
      n++;
    end while (rd[0] !== 1'b1 && n < 2000);
    if (rd[0] !== 1'b1) chk(1'b0, 1'b1);
  endtask

  // Full setup sequence from reset, then measure one steady period
  task automatic pwm_run(input int lim, input int psc, input int duty);
    int dv;
    dv = (psc == 0) ? 1 : (psc == 1) ? 4 : 16;
    // Fresh start: a lower limit must not meet a timer already past it
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1, cpw_pkg::ADDR_DIR, 1);
    apb(1, cpw_pkg::ADDR_PERIOD, lim);
    apb(1, cpw_pkg::ADDR_CTRL, {duty[1:0], cpw_pkg::MODE_PWM, 2'b00});
    apb(1, cpw_pkg::ADDR_DUTY_HI, duty >> 2);
    apb(1, cpw_pkg::ADDR_STATUS, 1);
    apb(1, cpw_pkg::ADDR_TCTRL, 4 | psc);
    wait_flag();
    apb(1, cpw_pkg::ADDR_DIR, 0);
    repeat (2) @(posedge pclk);
    chk(oe_n, 1'b0);
    repeat (12 * dv * (lim + 1) + 8) @(posedge pclk);
    chk(per_len, 4 * dv * (lim + 1));
    chk(hi_len, f_hi(duty, dv));
    apb(0, cpw_pkg::ADDR_INFO, 0);
    chk(rd[3:0], f_res(lim));
    chk(rd[26:16], 4 * (lim + 1));
  endtask

  initial begin
    #(40 * 100000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    int lim, t1;
    logic lv;
    {psel, penable, pwrite, sleep, paddr, pwdata} = '0;
    n_mismatch = 0;
    n_checks = 0;
    presetn = 1'b0;
    void'($urandom(13));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(oe_n, 1'b1);
    apb(0, cpw_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h00000000);
    chk(er, 1'b0);
    apb(0, cpw_pkg::ADDR_PERIOD, 0);
    chk(rd, 32'h000000FF);
    apb(0, cpw_pkg::ADDR_DIR, 0);
    chk(rd, 32'h00000001);
    apb(0, cpw_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h00000000);
    apb(0, 8'h24, 0);
    chk(er, 1'b1);
    // Corner cases first, then random settings, then the full limit of 255
    pwm_run(0, 0, 2);
    pwm_run(3, 0, 0);
    for (int i = 0; i < 6; i++) begin
      lim = $urandom_range(0, 15);
      pwm_run(lim, $urandom_range(0, 3), $urandom_range(0, 4 * lim + 2));
    end
    pwm_run(255, 0, 1000);
    // Flag is set here: mask gates the interrupt, one clock late
    chk(irq, 1'b0);
    apb(1, cpw_pkg::ADDR_MASK, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    // Stop the timer so no period end sets the flag being cleared
    apb(1, cpw_pkg::ADDR_TCTRL, 0);
    apb(1, cpw_pkg::ADDR_STATUS, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1, cpw_pkg::ADDR_TCTRL, 4);
    // Sleep freezes timer and pin; wake resumes from held count
    sleep <= 1'b1;
    apb(0, cpw_pkg::ADDR_TIMER, 0);
    t1 = rd;
    lv = pin;
    repeat (40) @(posedge pclk);
    apb(0, cpw_pkg::ADDR_TIMER, 0);
    chk(rd, t1);
    chk(pin, lv);
    sleep <= 1'b0;
    apb(0, cpw_pkg::ADDR_TIMER, 0);
    chk(8'(rd - t1) <= 8'h02, 1'b1);
    // Width above period: pin must hold its level
    apb(1, cpw_pkg::ADDR_PERIOD, 3);
    apb(1, cpw_pkg::ADDR_DUTY_HI, 4);
    // A lower limit lets the timer wrap; wait for a period end first
    apb(1, cpw_pkg::ADDR_STATUS, 1);
    wait_flag();
    lv = pin;
    repeat (40) @(posedge pclk);
    chk(pin, lv);
    // Mid-run reset returns pin to input
    presetn <= 1'b0;
    @(posedge pclk);
    chk(oe_n, 1'b1);
    presetn <= 1'b1;
    apb(0, cpw_pkg::ADDR_TCTRL, 0);
    chk(rd, 32'h00000000);
    tally_and_finish();
  end
endmodule // cpw_pwm_top_tb
